// >>> src/srlc_regs.svh
// Register indices, field positions, reset values and timing counts
`ifndef SRLC_REGS_SVH
`define SRLC_REGS_SVH

// ****************************************
// Register indices (byte address is four times the index)
// ****************************************
`define SRLC_IDX_GEN_CTRL     14'h0596
`define SRLC_IDX_SYNC_ERR     14'h0598
`define SRLC_IDX_FIFO_FULL    14'h05ad
`define SRLC_IDX_FIFO_EMPTY   14'h05ae
`define SRLC_IDX_IRQ_STATUS   14'h05bb
`define SRLC_IDX_IRQ_CLEAR    14'h05bc
`define SRLC_IDX_IRQ_ENABLE   14'h05bd
`define SRLC_IDX_SH_THRESH    14'h05be
`define SRLC_IDX_MB_THRESH    14'h05bf

// ****************************************
// Field positions
// ****************************************
`define SRLC_BIT_GEN_RSVD7    7
`define SRLC_BIT_LINK1_MERGE  6
`define SRLC_BIT_LINK0_MERGE  5
`define SRLC_BIT_DUAL_LINK    3
`define SRLC_BIT_INDEP_CTRL   2
`define SRLC_BIT_LINK1_EN     1
`define SRLC_BIT_LINK0_EN     0
`define SRLC_ERR_DUR_MSB      7
`define SRLC_ERR_DUR_LSB      4
`define SRLC_BIT_SH_IRQ       5
`define SRLC_BIT_MB_IRQ       4
`define SRLC_BIT_SH_IRQ_EN    2
`define SRLC_BIT_MB_IRQ_EN    1

// ****************************************
// Reset values and timing
// ****************************************
`define SRLC_RST_BYTE         8'h00
`define SRLC_PCLK_DIV         2

`endif

// >>> src/srlc_pkg.sv
// Types shared by the receiver link control block
package srlc_pkg;

	// Sync error pulse generator states
	typedef enum logic [0:0] {
		SRLC_GEN_IDLE,
		SRLC_GEN_LOW
	} srlc_gen_state_t;

	typedef logic [7:0] srlc_byte_t;

endpackage : srlc_pkg

// >>> src/srlc_sync_err_gen.sv
// Sync error report pulse generator, low time in half parallel-clock units
`timescale 1ns/1ps
module srlc_sync_err_gen #(
	parameter int CODE_W = 4
) (
	// Clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_resetn,
	// Control
	input  wire logic              i_pclk_en,
	input  wire logic              i_err,
	input  wire logic [CODE_W-1:0] i_code,
	// Report
	output logic                   o_low
);

	srlc_pkg::srlc_gen_state_t state;
	logic [CODE_W:0]           cnt;
	logic                      pending;
	logic                      start;
	logic [CODE_W:0]           len_cnt;
	logic [CODE_W:0]           len_exp;

	assign start = pending && i_pclk_en && (state == srlc_pkg::SRLC_GEN_IDLE);

	// ****************************************
	// Error capture
	// ****************************************
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pending <= 1'b0;
		end else if (i_err) begin
			pending <= 1'b1;
		end else if (start) begin
			pending <= 1'b0;
		end
	end

	// ****************************************
	// Low pulse timing
	// ****************************************
	// R6 - half plus code cycles
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= srlc_pkg::SRLC_GEN_IDLE;
			cnt   <= '0;
			o_low <= 1'b0;
		end else begin
			case (state)
				srlc_pkg::SRLC_GEN_IDLE: begin
					if (start) begin
						state <= srlc_pkg::SRLC_GEN_LOW;
						cnt   <= {i_code, 1'b1};
						o_low <= 1'b1;
					end
				end
				srlc_pkg::SRLC_GEN_LOW: begin
					if (cnt == {{CODE_W{1'b0}}, 1'b1}) begin
						state <= srlc_pkg::SRLC_GEN_IDLE;
						o_low <= 1'b0;
					end
					cnt <= cnt - {{CODE_W{1'b0}}, 1'b1};
				end
				default: begin
					state <= srlc_pkg::SRLC_GEN_IDLE;
					o_low <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			len_cnt <= '0;
			len_exp <= '0;
		end else begin
			if (start) begin
				len_exp <= {i_code, 1'b1};
			end
			len_cnt <= o_low ? len_cnt + {{CODE_W{1'b0}}, 1'b1} : '0;
		end
	end

	a_err_low_width: assert property (@(posedge i_clk) disable iff (!i_resetn) // R6
		$fell(o_low) |-> (len_cnt == len_exp))
		else $error("sync error low time wrong");

endmodule : srlc_sync_err_gen

// >>> src/srlc_top.sv
// Receiver link control and status registers with APB slave
//
// Behaviour
// R1 - Link1 merge drives combined sync on link1
// R2 - Link0 merge also drives combined on link1
// R3 - Mode bit: clear single, set dual
// R4 - Grouping bit: shared or independent link enables
// R5 - Enable bit per link, bit1 needs grouping
// R6 - Error report low for half plus code
// R7 - Software picks duration near half frame
// R8 - One duration field for both outputs
// R9 - Read per-lane FIFO full flags
// R10 - Read per-lane FIFO empty flags
// R11 - Sync header status on count over threshold
// R12 - Multiblock status on count over threshold
// R13 - Sync header interrupt gated by enable
// R14 - Multiblock interrupt gated by enable
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "srlc_regs.svh"
module srlc_top #(
	parameter int FULL_LANES  = 4,
	parameter int EMPTY_LANES = 8
) (
	// Clock and reset
	input  wire logic                   I_CLK,
	input  wire logic                   I_RESETN,
	// APB slave
	input  wire logic                   I_PSEL,
	input  wire logic                   I_PENABLE,
	input  wire logic                   I_PWRITE,
	input  wire logic [15:0]            I_PADDR,
	input  wire logic [31:0]            I_PWDATA,
	output logic [31:0]                 O_PRDATA,
	output logic                        O_PREADY,
	output logic                        O_PSLVERR,
	// Datapath status
	input  wire logic [1:0]             I_SYNC_REQ,
	input  wire logic [1:0]             I_SYNC_ERR,
	input  wire logic [FULL_LANES-1:0]  I_LANE_FIFO_FULL,
	input  wire logic [EMPTY_LANES-1:0] I_LANE_FIFO_EMPTY,
	input  wire logic                   I_SH_ALIGN_ERR,
	input  wire logic                   I_MB_ALIGN_ERR,
	// Link control
	output logic                        O_PCLK_EN,
	output logic [1:0]                  O_LINK_EN,
	output logic                        O_DUAL_LINK,
	output logic [1:0]                  O_SYNC_N,
	// Interrupt
	output logic                        O_IRQ
);

	// ****************************************
	// Declarations
	// ****************************************
	srlc_pkg::srlc_byte_t gen_ctrl;
	logic [3:0]           sync_error_low_duration;
	logic                 sync_header_error_irq;
	logic                 multiblock_error_irq;
	logic                 sync_header_irq_enable;
	logic                 multiblock_irq_enable;
	srlc_pkg::srlc_byte_t sh_thresh;
	srlc_pkg::srlc_byte_t mb_thresh;
	srlc_pkg::srlc_byte_t sh_count;
	srlc_pkg::srlc_byte_t mb_count;
	logic [13:0]          reg_idx;
	logic                 aligned;
	logic                 mapped;
	logic                 setup_rd;
	logic                 wr_en;
	logic [7:0]           wbyte;
	logic [31:0]          next_prdata;
	logic                 clr_sh;
	logic                 clr_mb;
	logic                 set_sh;
	logic                 set_mb;
	logic [1:0]           div_cnt;
	logic [1:0]           err_low;
	logic [1:0]           link_en;
	logic [1:0]           next_sync_n;
	logic                 first_link_sync_merge;
	logic                 second_link_sync_merge;
	logic                 dual_link_select;
	logic                 independent_link_control;
	logic [1:0]           receiver_link_enables;

	assign first_link_sync_merge    = gen_ctrl[`SRLC_BIT_LINK0_MERGE];
	assign second_link_sync_merge   = gen_ctrl[`SRLC_BIT_LINK1_MERGE];
	assign dual_link_select         = gen_ctrl[`SRLC_BIT_DUAL_LINK];
	assign independent_link_control = gen_ctrl[`SRLC_BIT_INDEP_CTRL];
	assign receiver_link_enables    = gen_ctrl[`SRLC_BIT_LINK1_EN:`SRLC_BIT_LINK0_EN];

	// ****************************************
	// APB decode
	// ****************************************
	assign reg_idx  = I_PADDR[15:2];
	assign aligned  = (I_PADDR[1:0] == 2'h0);
	assign setup_rd = I_PSEL && !I_PENABLE && !I_PWRITE;
	assign wr_en    = I_PSEL && I_PENABLE && I_PWRITE && aligned;
	assign wbyte    = I_PWDATA[7:0];

	always_comb begin
		case (reg_idx)
			`SRLC_IDX_GEN_CTRL,
			`SRLC_IDX_SYNC_ERR,
			`SRLC_IDX_FIFO_FULL,
			`SRLC_IDX_FIFO_EMPTY,
			`SRLC_IDX_IRQ_STATUS,
			`SRLC_IDX_IRQ_CLEAR,
			`SRLC_IDX_IRQ_ENABLE,
			`SRLC_IDX_SH_THRESH,
			`SRLC_IDX_MB_THRESH: mapped = aligned;
			default: mapped = 1'b0;
		endcase
	end

	assign O_PREADY  = 1'b1;
	assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;

	// ****************************************
	// Read data
	// ****************************************
	always_comb begin
		next_prdata = 32'h0000_0000;
		if (aligned) begin
			case (reg_idx)
				`SRLC_IDX_GEN_CTRL:   next_prdata[7:0] = gen_ctrl;
				`SRLC_IDX_SYNC_ERR:   next_prdata[7:4] = sync_error_low_duration;
				// R9 - full flags view
				`SRLC_IDX_FIFO_FULL:  next_prdata[FULL_LANES-1:0] = I_LANE_FIFO_FULL;
				// R10 - empty flags view
				`SRLC_IDX_FIFO_EMPTY: next_prdata[EMPTY_LANES-1:0] = I_LANE_FIFO_EMPTY;
				`SRLC_IDX_IRQ_STATUS: begin
					next_prdata[`SRLC_BIT_SH_IRQ]    = sync_header_error_irq;
					next_prdata[`SRLC_BIT_MB_IRQ]    = multiblock_error_irq;
					next_prdata[`SRLC_BIT_SH_IRQ_EN] = sync_header_irq_enable;
					next_prdata[`SRLC_BIT_MB_IRQ_EN] = multiblock_irq_enable;
				end
				`SRLC_IDX_IRQ_ENABLE: begin
					next_prdata[`SRLC_BIT_SH_IRQ] = sync_header_irq_enable;
					next_prdata[`SRLC_BIT_MB_IRQ] = multiblock_irq_enable;
				end
				`SRLC_IDX_SH_THRESH:  next_prdata[7:0] = sh_thresh;
				`SRLC_IDX_MB_THRESH:  next_prdata[7:0] = mb_thresh;
				default:              next_prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_PRDATA <= 32'h0000_0000;
		end else if (setup_rd) begin
			O_PRDATA <= next_prdata;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	// R3 - mode defaults single
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			gen_ctrl <= `SRLC_RST_BYTE;
		end else if (wr_en && (reg_idx == `SRLC_IDX_GEN_CTRL)) begin
			gen_ctrl <= wbyte & 8'hef;
		end
	end

	// R8 - one shared duration
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			sync_error_low_duration <= 4'h0;
		end else if (wr_en && (reg_idx == `SRLC_IDX_SYNC_ERR)) begin
			sync_error_low_duration <= wbyte[`SRLC_ERR_DUR_MSB:`SRLC_ERR_DUR_LSB];
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			sh_thresh <= `SRLC_RST_BYTE;
			mb_thresh <= `SRLC_RST_BYTE;
		end else if (wr_en && (reg_idx == `SRLC_IDX_SH_THRESH)) begin
			sh_thresh <= wbyte;
		end else if (wr_en && (reg_idx == `SRLC_IDX_MB_THRESH)) begin
			mb_thresh <= wbyte;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			sync_header_irq_enable <= 1'b0;
			multiblock_irq_enable  <= 1'b0;
		end else if (wr_en && (reg_idx == `SRLC_IDX_IRQ_STATUS)) begin
			sync_header_irq_enable <= wbyte[`SRLC_BIT_SH_IRQ_EN];
			multiblock_irq_enable  <= wbyte[`SRLC_BIT_MB_IRQ_EN];
		end else if (wr_en && (reg_idx == `SRLC_IDX_IRQ_ENABLE)) begin
			sync_header_irq_enable <= wbyte[`SRLC_BIT_SH_IRQ];
			multiblock_irq_enable  <= wbyte[`SRLC_BIT_MB_IRQ];
		end
	end

	// ****************************************
	// Alignment error counting and status
	// ****************************************
	assign clr_sh = wr_en && (reg_idx == `SRLC_IDX_IRQ_CLEAR) && wbyte[`SRLC_BIT_SH_IRQ];
	assign clr_mb = wr_en && (reg_idx == `SRLC_IDX_IRQ_CLEAR) && wbyte[`SRLC_BIT_MB_IRQ];
	assign set_sh = (sh_count > sh_thresh) && !clr_sh;
	assign set_mb = (mb_count > mb_thresh) && !clr_mb;

	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			sh_count <= `SRLC_RST_BYTE;
			mb_count <= `SRLC_RST_BYTE;
		end else begin
			if (clr_sh) begin
				sh_count <= {7'h00, I_SH_ALIGN_ERR};
			end else if (I_SH_ALIGN_ERR && (sh_count != 8'hff)) begin
				sh_count <= sh_count + 8'h01;
			end
			if (clr_mb) begin
				mb_count <= {7'h00, I_MB_ALIGN_ERR};
			end else if (I_MB_ALIGN_ERR && (mb_count != 8'hff)) begin
				mb_count <= mb_count + 8'h01;
			end
		end
	end

	// R11 - sync header status
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			sync_header_error_irq <= 1'b0;
		end else if (set_sh) begin
			sync_header_error_irq <= 1'b1;
		end else if (clr_sh) begin
			sync_header_error_irq <= 1'b0;
		end
	end

	// R12 - multiblock status
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			multiblock_error_irq <= 1'b0;
		end else if (set_mb) begin
			multiblock_error_irq <= 1'b1;
		end else if (clr_mb) begin
			multiblock_error_irq <= 1'b0;
		end
	end

	// R13 - R14 enable gated interrupt
	assign O_IRQ = (sync_header_error_irq && sync_header_irq_enable)
		|| (multiblock_error_irq && multiblock_irq_enable);

	// ****************************************
	// Parallel clock enable
	// ****************************************
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			div_cnt <= 2'h0;
		end else if (div_cnt == 2'(`SRLC_PCLK_DIV - 1)) begin
			div_cnt <= 2'h0;
		end else begin
			div_cnt <= div_cnt + 2'h1;
		end
	end

	assign O_PCLK_EN = (div_cnt == 2'(`SRLC_PCLK_DIV - 1));

	// ****************************************
	// Link enables and mode
	// ****************************************
	// R4 - R5 link enable grouping
	assign link_en[0] = receiver_link_enables[0];
	assign link_en[1] = independent_link_control ? receiver_link_enables[1]
		: receiver_link_enables[0];

	assign O_LINK_EN   = link_en;
	assign O_DUAL_LINK = dual_link_select;

	// ****************************************
	// Sync request outputs
	// ****************************************
	// R6 - R8 shared duration generators
	generate
		for (genvar k = 0; k < 2; k++) begin : g_err
			srlc_sync_err_gen #(
				.CODE_W (4)
			) u_gen (
				.i_clk     (I_CLK),
				.i_resetn  (I_RESETN),
				.i_pclk_en (O_PCLK_EN),
				.i_err     (I_SYNC_ERR[k]),
				.i_code    (sync_error_low_duration),
				.o_low     (err_low[k])
			);
		end
	endgenerate

	always_comb begin
		next_sync_n[0] = link_en[0] && !I_SYNC_REQ[0] && !err_low[0];
		// R1 - R2 combined link1 output
		if (second_link_sync_merge || first_link_sync_merge) begin
			next_sync_n[1] = link_en[1] && !(I_SYNC_REQ[0] || err_low[0]
				|| I_SYNC_REQ[1] || err_low[1]);
		end else begin
			next_sync_n[1] = link_en[1] && !I_SYNC_REQ[1] && !err_low[1];
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_SYNC_N <= 2'h0;
		end else begin
			O_SYNC_N <= next_sync_n;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_link1_merge_out: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // R1
		second_link_sync_merge && link_en[1] |=> O_SYNC_N[1] == !($past(I_SYNC_REQ[0])
			|| $past(err_low[0]) || $past(I_SYNC_REQ[1]) || $past(err_low[1])))
		else $error("link1 merged sync wrong");

	a_link0_merge_out: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // R2
		first_link_sync_merge && link_en[1] && I_SYNC_REQ[0] |=> !O_SYNC_N[1])
		else $error("link0 merge not on link1 output");

	a_mode_reset_single: assert property (@(posedge I_CLK) // R3
		$rose(I_RESETN) |-> !O_DUAL_LINK)
		else $error("mode not single after reset");

	a_link_shared_enable: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // R4
		!independent_link_control |-> (O_LINK_EN[1] == O_LINK_EN[0]))
		else $error("links not enabled together");

	a_link1_own_enable: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // R5
		independent_link_control |-> (O_LINK_EN == receiver_link_enables))
		else $error("independent enable wrong");

	a_shared_duration: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // R8
		I_SYNC_ERR[0] && I_SYNC_ERR[1] && !err_low[0] && !err_low[1]
			&& $stable(sync_error_low_duration) |=> ##[1:4] (err_low[0] == err_low[1]))
		else $error("duration not shared");

	a_fifo_full_view: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // R9
		setup_rd && aligned && (reg_idx == `SRLC_IDX_FIFO_FULL)
			|=> O_PRDATA == {{(32-FULL_LANES){1'b0}}, $past(I_LANE_FIFO_FULL)})
		else $error("full flags read wrong");

	a_fifo_empty_view: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // R10
		setup_rd && aligned && (reg_idx == `SRLC_IDX_FIFO_EMPTY)
			|=> O_PRDATA == {{(32-EMPTY_LANES){1'b0}}, $past(I_LANE_FIFO_EMPTY)})
		else $error("empty flags read wrong");

	a_sh_status_set: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // R11
		(sh_count > sh_thresh) && !clr_sh |=> sync_header_error_irq)
		else $error("sync header status not set");

	a_mb_status_set: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // R12
		(mb_count > mb_thresh) && !clr_mb |=> multiblock_error_irq)
		else $error("multiblock status not set");

	a_sh_irq_gate: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // R13
		!multiblock_error_irq |-> (O_IRQ == (sync_header_error_irq && sync_header_irq_enable)))
		else $error("sync header interrupt gating wrong");

	a_mb_irq_gate: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // R14
		!sync_header_error_irq |-> (O_IRQ == (multiblock_error_irq && multiblock_irq_enable)))
		else $error("multiblock interrupt gating wrong");

endmodule : srlc_top

// >>> test/srlc_sync_monitor.sv
// Far-side sync receiver model measuring low runs on the sync outputs
`timescale 1ns/1ps
module srlc_sync_monitor (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	// Sync request outputs of the device
	input  wire logic [1:0] i_sync_n,
	// Measurements
	output logic [1:0][7:0] o_low_len,
	output logic [1:0][7:0] o_runs
);
	logic [1:0][7:0] cnt;

	// ****************
	// Low run measurement
	// ****************
	// width of each low run
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt       <= '0;
			o_low_len <= '0;
			o_runs    <= '0;
		end else begin
			for (int k = 0; k < 2; k++) begin
				if (!i_sync_n[k]) begin
					cnt[k] <= cnt[k] + 8'h01;
				end else if (cnt[k] != 8'h00) begin
					o_low_len[k] <= cnt[k];
					o_runs[k]    <= o_runs[k] + 8'h01;
					cnt[k]       <= 8'h00;
				end
			end
		end
	end
endmodule : srlc_sync_monitor

// >>> test/test_serial_rx_link_control.sv
// Self-checking bench for the receiver link control registers
`timescale 1ns/1ps
`include "srlc_regs.svh"
module test_serial_rx_link_control;
	logic              clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic [15:0]       paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic [1:0]        sync_req, sync_err, link_en, sync_n;
	logic [3:0]        fifo_full;
	logic [7:0]        fifo_empty;
	logic              sh_err, mb_err, pclk_en, dual_link, irq, er;
	logic [1:0][7:0]   low_len, runs;
	int                err_count, num_checks;

	srlc_top #(.FULL_LANES(4), .EMPTY_LANES(8)) dut (
		.I_CLK(clk), .I_RESETN(resetn), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_SYNC_REQ(sync_req),
		.I_SYNC_ERR(sync_err), .I_LANE_FIFO_FULL(fifo_full),
		.I_LANE_FIFO_EMPTY(fifo_empty), .I_SH_ALIGN_ERR(sh_err), .I_MB_ALIGN_ERR(mb_err),
		.O_PCLK_EN(pclk_en), .O_LINK_EN(link_en), .O_DUAL_LINK(dual_link),
		.O_SYNC_N(sync_n), .O_IRQ(irq));
	srlc_sync_monitor mon (.i_clk(clk), .i_resetn(resetn), .i_sync_n(sync_n),
		.o_low_len(low_len), .o_runs(runs));

	// ****************
	// Shared tasks
	// ****************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic apb(input logic wr, input logic [13:0] idx, input logic [7:0] wd);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h000000, wd};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdchk(input logic [13:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(rd, exp);
		chk(32'(er), 32'h0);
	endtask : rdchk

	task automatic pulse(input int k, input int n);
		{mb_err, sh_err} <= (k != 0) ? 2'b10 : 2'b01;
		cyc(n);
		{mb_err, sh_err} <= 2'b00;
		cyc(3);
	endtask : pulse

	// ****************
	// Scenarios
	// ****************
	// reset values
	task automatic t_reset();
		logic p;
		chk(32'(dual_link), 32'h0);
		chk(32'(link_en), 32'h0);
		rdchk(`SRLC_IDX_GEN_CTRL, 32'h0);
		rdchk(`SRLC_IDX_IRQ_STATUS, 32'h0);
		p = pclk_en;
		cyc(1);
		chk(32'(pclk_en), 32'(!p));
	endtask : t_reset

	task automatic t_ctrl();
		logic [7:0] v;
		logic [7:0] tbl [8] = '{8'h00, 8'h01, 8'h02, 8'h06, 8'h05, 8'h07, 8'h08, 8'h0b};
		foreach (tbl[i]) begin
			v = tbl[i];
			apb(1'b1, `SRLC_IDX_GEN_CTRL, v);
			cyc(1);
			chk(32'(link_en), 32'({v[2] ? v[1] : v[0], v[0]}));
			chk(32'(dual_link), 32'(v[3]));
		end
		apb(1'b1, `SRLC_IDX_GEN_CTRL, 8'hff);
		rdchk(`SRLC_IDX_GEN_CTRL, 32'hef);
		apb(1'b1, `SRLC_IDX_SYNC_ERR, 8'hff);
		rdchk(`SRLC_IDX_SYNC_ERR, 32'hf0);
	endtask : t_ctrl

	task automatic t_merge();
		logic [11:0] m [9] = '{12'h076, 12'h474, 12'h274, 12'h079, 12'h479,
			12'h279, 12'h073, 12'h473, 12'h051};
		foreach (m[i]) begin
			apb(1'b1, `SRLC_IDX_GEN_CTRL, m[i][11:4]);
			sync_req <= m[i][3:2];
			cyc(3);
			chk(32'(sync_n), 32'(m[i][1:0]));
		end
		sync_req <= 2'b00;
	endtask : t_merge

	// error report low time on both outputs
	task automatic t_pulse();
		logic [7:0] r;
		int         n;
		logic [3:0] codes [4] = '{4'h0, 4'h1, 4'h3, 4'hf};
		apb(1'b1, `SRLC_IDX_GEN_CTRL, 8'h07);
		foreach (codes[i]) begin
			for (int k = 0; k < 2; k++) begin
				apb(1'b1, `SRLC_IDX_SYNC_ERR, {codes[i], 4'h0});
				cyc(4);
				r = runs[k];
				sync_err[k] <= 1'b1;
				cyc(1);
				sync_err <= 2'b00;
				n = 0;
				while (runs[k] === r && n < 100) begin
					cyc(1);
					n++;
				end
				chk(32'(n < 100), 32'h1);
				chk(32'(low_len[k]), 32'(2 * codes[i] + 1));
			end
		end
		apb(1'b1, `SRLC_IDX_SYNC_ERR, 8'h20);
		cyc(4);
		r = runs[1];
		sync_err <= 2'b11;
		cyc(1);
		sync_err <= 2'b00;
		n = 0;
		while (runs[1] === r && n < 100) begin
			cyc(1);
			n++;
		end
		chk(32'(n < 100), 32'h1);
		chk(32'(low_len[0]), 32'h5);
		chk(32'(low_len[1]), 32'h5);
	endtask : t_pulse

	task automatic t_fifo();
		logic [7:0] p [2] = '{8'h5a, 8'ha5};
		foreach (p[i]) begin
			fifo_full  <= p[i][3:0];
			fifo_empty <= p[i];
			apb(1'b1, `SRLC_IDX_FIFO_FULL, 8'hff);
			rdchk(`SRLC_IDX_FIFO_FULL, 32'(p[i][3:0]));
			rdchk(`SRLC_IDX_FIFO_EMPTY, 32'(p[i]));
		end
	endtask : t_fifo

	task automatic t_map();
		apb(1'b1, `SRLC_IDX_SYNC_ERR, 8'h50);
		apb(1'b1, `SRLC_IDX_SYNC_ERR + 14'h1, 8'hff);
		chk(32'(er), 32'h1);
		apb(1'b0, `SRLC_IDX_SYNC_ERR - 14'h1, 8'h00);
		chk(rd, 32'h0);
		chk(32'(er), 32'h1);
		rdchk(`SRLC_IDX_SYNC_ERR, 32'h50);
	endtask : t_map

	task automatic t_irq();
		logic [7:0] sb, eb;
		for (int k = 0; k < 2; k++) begin
			sb = (k != 0) ? 8'h10 : 8'h20;
			eb = sb >> 3;
			apb(1'b1, (k != 0) ? `SRLC_IDX_MB_THRESH : `SRLC_IDX_SH_THRESH, 8'h02);
			pulse(k, 2);
			rdchk(`SRLC_IDX_IRQ_STATUS, 32'h0);
			pulse(k, 1);
			rdchk(`SRLC_IDX_IRQ_STATUS, 32'(sb));
			chk(32'(irq), 32'h0);
			apb(1'b1, (k != 0) ? `SRLC_IDX_IRQ_ENABLE : `SRLC_IDX_IRQ_STATUS,
				(k != 0) ? sb : eb);
			cyc(1);
			chk(32'(irq), 32'h1);
			rdchk(`SRLC_IDX_IRQ_STATUS, 32'(sb | eb));
			rdchk(`SRLC_IDX_IRQ_ENABLE, 32'(sb));
			apb(1'b1, `SRLC_IDX_IRQ_CLEAR, sb);
			cyc(1);
			chk(32'(irq), 32'h0);
			rdchk(`SRLC_IDX_IRQ_CLEAR, 32'h0);
			rdchk(`SRLC_IDX_IRQ_STATUS, 32'(eb));
			apb(1'b1, `SRLC_IDX_IRQ_STATUS, 8'h00);
		end
	endtask : t_irq

	task automatic summarize();
		if (err_count == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize

	// ****************
	// Clock, sequence, watchdog
	// ****************
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		{psel, penable, pwrite, sh_err, mb_err} = 5'h00;
		{paddr, pwdata, sync_req, sync_err} = '0;
		{fifo_full, fifo_empty} = '0;
		err_count  = 0;
		num_checks = 0;
		resetn     = 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_ctrl();
		t_merge();
		t_pulse();
		t_fifo();
		t_map();
		t_irq();
		summarize();
	end

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		summarize();
	end
endmodule : test_serial_rx_link_control
